/* File: hdl/dpw_pin_sync.sv */
// Two-stage synchroniser for the three link pins.
// Assumes pins are asynchronous to i_clk_sys; the first stage is read
// only by the second.

`timescale 1ns/1ps

module dpw_pin_sync (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst,
   input  wire dpw_pkg::dpw_pins_s i_pins,
   output dpw_pkg::dpw_pins_s      o_pins
);

   dpw_pkg::dpw_pins_s meta_q;
   dpw_pkg::dpw_pins_s sync_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_q <= dpw_pkg::DPW_PINS_RST;
         sync_q <= dpw_pkg::DPW_PINS_RST;
      end else begin
         meta_q <= i_pins;
         sync_q <= meta_q;
      end
   end

   assign o_pins = sync_q;

endmodule : dpw_pin_sync

/* File: hdl/dpw_pkg.sv */
// Shared types and constants of the serial wiper loader.
// Assumes a single system clock domain; pins arrive asynchronously.

package dpw_pkg;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int          DPW_CODE_W    = 8;
   localparam int          DPW_TAP_COUNT = 256;
   localparam int          DPW_CNT_W     = 4;
   localparam logic [7:0]  DPW_WIPER_RST = 8'h80;
   localparam logic [7:0]  DPW_SHIFT_RST = 8'h00;
   localparam logic [3:0]  DPW_CNT_RST   = 4'h0;
   localparam logic [3:0]  DPW_CNT_MAX   = 4'hF;
   localparam logic [3:0]  DPW_WORD_BITS = 4'h8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic [DPW_CODE_W-1:0]    dpw_code_t;
   typedef logic [DPW_TAP_COUNT-1:0] dpw_taps_t;

   // Three-wire control link, sampled as a group.
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic serial_data_input;
   } dpw_pins_s;

   localparam dpw_pins_s DPW_PINS_RST = '{cs_n: 1'b1, sclk: 1'b0,
                                          serial_data_input: 1'b0};

   typedef enum logic {
      DPW_FRM_IDLE,
      DPW_FRM_ACTIVE
   } dpw_frame_e;

endpackage : dpw_pkg

/* File: hdl/dpw_tap_decoder.sv */
// Registered one-hot decoder from wiper code to tap select.
// Assumes the code comes from logic on the same clock.

`timescale 1ns/1ps

module dpw_tap_decoder (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst,
   input  wire dpw_pkg::dpw_code_t i_code,
   output dpw_pkg::dpw_taps_t      o_taps
);

   dpw_pkg::dpw_taps_t taps_d;
   dpw_pkg::dpw_taps_t taps_q;

   // Code zero is the bottom contact; each step moves one tap upward.
   for (genvar g = 0; g < dpw_pkg::DPW_TAP_COUNT; g++) begin : g_tap
      assign taps_d[g] = (i_code == dpw_pkg::DPW_CODE_W'(g));
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         taps_q <= dpw_pkg::DPW_TAP_COUNT'(1) << dpw_pkg::DPW_WIPER_RST;
      end else begin
         taps_q <= taps_d;
      end
   end

   assign o_taps = taps_q;

endmodule : dpw_tap_decoder

/* File: hdl/dpw_wiper_loader.sv */
// Serial wiper loader: three-wire write-only receiver and wiper register.
// Assumes link pins are asynchronous to i_clk_sys and that the link
// clock is several system clocks per phase; reset stands for power-up.
//
// Summary of operation
// - Wiper stays midscale until first chip-select rise.
// - Reset clears shifter, presets wiper to 0x80.
// - Chip-select rise copies shifter into wiper.
// - Copy happens even with no bits shifted.
// - Shift one bit per clock rise while selected.
// - Surplus bits drop out; last eight kept.
// - Wiper code decodes to one-hot tap select.
// - Code zero selects bottom; higher codes step up.
// - Higher code moves tap further from bottom.
// - Only three input lines; no readback output.

`timescale 1ns/1ps

module dpw_wiper_loader (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst,
   input  wire logic               i_cs_n,
   input  wire logic               i_sclk,
   input  wire logic               i_serial_data_input,
   output dpw_pkg::dpw_code_t      o_wiper_code,
   output dpw_pkg::dpw_taps_t      o_tap_sel,
   output logic                    o_frame_active
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   dpw_pkg::dpw_pins_s pins_raw;
   dpw_pkg::dpw_pins_s pins_s;
   dpw_pkg::dpw_pins_s pins_prev_q;

   // The link has only inputs; nothing is ever driven back.
   assign pins_raw = '{cs_n: i_cs_n, sclk: i_sclk,
                       serial_data_input: i_serial_data_input};

   dpw_pin_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_pins    (pins_raw),
      .o_pins    (pins_s)
   );

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pins_prev_q <= dpw_pkg::DPW_PINS_RST;
      end else begin
         pins_prev_q <= pins_s;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic cs_rise;
   logic cs_fall;
   logic sclk_rise;
   logic shift_en;

   assign cs_rise   = pins_s.cs_n & ~pins_prev_q.cs_n;
   assign cs_fall   = ~pins_s.cs_n & pins_prev_q.cs_n;
   assign sclk_rise = pins_s.sclk & ~pins_prev_q.sclk;

   // Clock edges only count while chip select is low.
   assign shift_en  = sclk_rise & ~pins_s.cs_n;

   // ----------------------------------------------------------------
   // Input shift register
   // ----------------------------------------------------------------
   dpw_pkg::dpw_code_t shift_q;
   dpw_pkg::dpw_code_t shift_d;

   // New bits enter at the bottom, so the oldest bit leaves at the top
   // and a long frame keeps only its last eight bits.
   assign shift_d = {shift_q[dpw_pkg::DPW_CODE_W-2:0],
                     pins_s.serial_data_input};

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         shift_q <= dpw_pkg::DPW_SHIFT_RST;
      end else if (shift_en) begin
         shift_q <= shift_d;
      end
   end

   // ----------------------------------------------------------------
   // Wiper register
   // ----------------------------------------------------------------
   dpw_pkg::dpw_code_t wiper_q;

   // The rise of chip select is the transfer command, whether or not
   // any bits were shifted since power-up.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wiper_q <= dpw_pkg::DPW_WIPER_RST;
      end else if (cs_rise) begin
         wiper_q <= shift_q;
      end
   end

   assign o_wiper_code = wiper_q;

   // ----------------------------------------------------------------
   // Tap decode
   // ----------------------------------------------------------------
   dpw_tap_decoder u_decoder (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_code    (wiper_q),
      .o_taps    (o_tap_sel)
   );

   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   dpw_pkg::dpw_frame_e frame_q;
   logic [dpw_pkg::DPW_CNT_W-1:0] bit_cnt_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         frame_q <= dpw_pkg::DPW_FRM_IDLE;
      end else begin
         unique case (frame_q)
            dpw_pkg::DPW_FRM_IDLE: begin
               if (cs_fall) begin
                  frame_q <= dpw_pkg::DPW_FRM_ACTIVE;
               end
            end
            dpw_pkg::DPW_FRM_ACTIVE: begin
               if (cs_rise) begin
                  frame_q <= dpw_pkg::DPW_FRM_IDLE;
               end
            end
         endcase
      end
   end

   // Bits seen in the current frame, saturating.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         bit_cnt_q <= dpw_pkg::DPW_CNT_RST;
      end else if (cs_fall) begin
         bit_cnt_q <= dpw_pkg::DPW_CNT_RST;
      end else if (shift_en && bit_cnt_q != dpw_pkg::DPW_CNT_MAX) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_frame_active <= 1'b0;
      end else begin
         o_frame_active <= ~pins_s.cs_n;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb_sys @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // Release from reset shows the power-up values.
   property p_reset_values;
      $past(i_rst) |-> wiper_q == dpw_pkg::DPW_WIPER_RST
                       && shift_q == dpw_pkg::DPW_SHIFT_RST;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("power-up values wrong after reset");

   // With no chip-select rise the wiper holds its value.
   property p_wiper_hold;
      !cs_rise |=> $stable(wiper_q);
   endproperty
   a_wiper_hold: assert property (p_wiper_hold)
      else $error("wiper changed without a chip-select rise");

   // Midscale tap stays selected while wiper is at reset value.
   property p_mid_tap;
      (wiper_q == dpw_pkg::DPW_WIPER_RST) [*2]
         |-> o_tap_sel[dpw_pkg::DPW_WIPER_RST];
   endproperty
   a_mid_tap: assert property (p_mid_tap)
      else $error("midscale tap not selected");

   // A chip-select rise loads the shifter into the wiper.
   property p_copy;
      cs_rise |=> wiper_q == $past(shift_q);
   endproperty
   a_copy: assert property (p_copy)
      else $error("wiper not loaded on chip-select rise");

   // A bare toggle after reset sends the wiper to the bottom tap.
   property p_toggle_zero;
      cs_rise && shift_q == dpw_pkg::DPW_SHIFT_RST
         |=> wiper_q == dpw_pkg::DPW_SHIFT_RST ##1 o_tap_sel[0];
   endproperty
   a_toggle_zero: assert property (p_toggle_zero)
      else $error("empty transfer did not select bottom tap");

   // Each selected clock rise shifts in the sampled data bit.
   property p_shift;
      sclk_rise && !pins_s.cs_n |=>
         shift_q == {$past(shift_q[6:0]),
                     $past(pins_s.serial_data_input)};
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift register did not take the data bit");

   // Past the eighth bit of a frame, every shift pushes the oldest
   // bit out of the top.
   property p_surplus_drop;
      shift_en && bit_cnt_q >= dpw_pkg::DPW_WORD_BITS
         |=> shift_q[7:1] == $past(shift_q[6:0]);
   endproperty
   a_surplus_drop: assert property (p_surplus_drop)
      else $error("surplus bit not dropped from the shifter");

   // Deselected: the shifter never moves.
   property p_ignore_deselected;
      pins_s.cs_n |=> $stable(shift_q);
   endproperty
   a_ignore_deselected: assert property (p_ignore_deselected)
      else $error("shift register moved while deselected");

   // Exactly one tap is selected at all times.
   property p_one_hot;
      $onehot(o_tap_sel);
   endproperty
   a_one_hot: assert property (p_one_hot)
      else $error("tap select is not one-hot");

   // The selected tap index equals the wiper code one cycle earlier.
   property p_tap_index;
      1'b1 |=> o_tap_sel
               == (dpw_pkg::DPW_TAP_COUNT'(1) << $past(wiper_q));
   endproperty
   a_tap_index: assert property (p_tap_index)
      else $error("tap select does not follow the wiper code");

   // A larger loaded code selects a higher tap than before.
   property p_monotonic;
      $changed(wiper_q) && wiper_q > $past(wiper_q)
         |=> (o_tap_sel >> 1) >= $past(o_tap_sel);
   endproperty
   a_monotonic: assert property (p_monotonic)
      else $error("higher code did not move tap upward");

   // The frame flag follows the synchronised chip select.
   property p_frame_flag;
      1'b1 |=> o_frame_active == !$past(pins_s.cs_n);
   endproperty
   a_frame_flag: assert property (p_frame_flag)
      else $error("frame flag does not follow chip select");

   // The frame state agrees with the frame flag at every edge.
   property p_frame_state;
      (frame_q == dpw_pkg::DPW_FRM_ACTIVE) == o_frame_active;
   endproperty
   a_frame_state: assert property (p_frame_state)
      else $error("frame state and frame flag disagree");

   // The bit count moves only on a selected shift or a frame start.
   property p_count_hold;
      !shift_en && !cs_fall |=> $stable(bit_cnt_q);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("bit count moved without a selected shift");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   property p_word_loaded;
      cs_rise && bit_cnt_q == dpw_pkg::DPW_WORD_BITS;
   endproperty
   c_word_loaded: cover property (p_word_loaded);

   property p_empty_toggle;
      cs_rise && bit_cnt_q == dpw_pkg::DPW_CNT_RST
         && frame_q == dpw_pkg::DPW_FRM_ACTIVE;
   endproperty
   c_empty_toggle: cover property (p_empty_toggle);

   property p_long_frame;
      cs_rise && bit_cnt_q > dpw_pkg::DPW_WORD_BITS;
   endproperty
   c_long_frame: cover property (p_long_frame);

   property p_top_tap;
      o_tap_sel[dpw_pkg::DPW_TAP_COUNT-1];
   endproperty
   c_top_tap: cover property (p_top_tap);

   property p_stray_clock;
      sclk_rise && pins_s.cs_n;
   endproperty
   c_stray_clock: cover property (p_stray_clock);

endmodule : dpw_wiper_loader

/* File: verification/dpw_spi_ctrl_model.sv */
// Behavioural serial controller that drives the wiper loader's link pins.
// Assumes the bench calls its tasks one at a time from a single process.

`timescale 1ns/1ps

module dpw_spi_ctrl_model #(
   parameter int HALF = 20
) (
   input  wire logic i_clk_sys,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_serial_data_input
);

   initial begin
      o_cs_n              = 1'b1;
      o_sclk              = 1'b0;
      o_serial_data_input = 1'b0;
   end

   task automatic wait_half();
      repeat (HALF) @(posedge i_clk_sys);
   endtask : wait_half

   task automatic select();
      @(posedge i_clk_sys);
      o_cs_n <= 1'b0;
      wait_half();
   endtask : select

   // Data changes while the link clock is low, so it is steady at the rise.
   task automatic shift_bit(input logic b);
      @(posedge i_clk_sys);
      o_serial_data_input <= b;
      wait_half();
      o_sclk <= 1'b1;
      wait_half();
      o_sclk <= 1'b0;
   endtask : shift_bit

   // Released data line shows the inverse level, not the last bit.
   task automatic deselect();
      wait_half();
      o_cs_n              <= 1'b1;
      o_serial_data_input <= ~o_serial_data_input;
      wait_half();
   endtask : deselect

   // Link clock pulses with the device deselected, on purpose.
   task automatic stray_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk_sys);
         o_serial_data_input <= ~o_serial_data_input;
         wait_half();
         o_sclk <= 1'b1;
         wait_half();
         o_sclk <= 1'b0;
      end
   endtask : stray_clocks

endmodule : dpw_spi_ctrl_model

/* File: verification/tb_dpw_wiper_loader.sv */
// Self-checking bench for the serial wiper loader.
// Assumes the controller model drives every link pin of the block.

`timescale 1ns/1ps

module tb_dpw_wiper_loader;

   localparam int LIMIT = 20000;

   logic                i_clk_sys;
   logic                i_rst;
   logic                cs_n;
   logic                sclk;
   logic                serial_data_input;
   dpw_pkg::dpw_code_t  wiper;
   dpw_pkg::dpw_taps_t  taps;
   logic                frame;
   int                  mismatches;
   int                  compares;
   int                  cycles;

   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   dpw_spi_ctrl_model dpw_spi_ctrl_model_inst (
      .i_clk_sys           (i_clk_sys),
      .o_cs_n              (cs_n),
      .o_sclk              (sclk),
      .o_serial_data_input (serial_data_input)
   );

   dpw_wiper_loader dpw_wiper_loader_inst (
      .i_clk_sys           (i_clk_sys),
      .i_rst               (i_rst),
      .i_cs_n              (cs_n),
      .i_sclk              (sclk),
      .i_serial_data_input (serial_data_input),
      .o_wiper_code        (wiper),
      .o_tap_sel           (taps),
      .o_frame_active      (frame)
   );

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic check_wiper(input logic [7:0] exp);
      repeat (8) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      cmp(256'(wiper), 256'(exp));
      cmp(taps, dpw_pkg::dpw_taps_t'(1) << exp);
      cmp(256'(frame), 256'h0);
   endtask : check_wiper

   task automatic send_bits(input logic [15:0] v);
      dpw_spi_ctrl_model_inst.select();
      @(negedge i_clk_sys);
      cmp(256'(frame), 256'h1);
      for (int i = 15; i >= 0; i--) begin
         dpw_spi_ctrl_model_inst.shift_bit(v[i]);
      end
      dpw_spi_ctrl_model_inst.deselect();
   endtask : send_bits

   task automatic t_power_up();
      check_wiper(8'h80);
      repeat (200) @(posedge i_clk_sys);
      check_wiper(8'h80);
      $display("test power_up done");
   endtask : t_power_up

   task automatic t_empty_frame();
      dpw_spi_ctrl_model_inst.select();
      dpw_spi_ctrl_model_inst.deselect();
      check_wiper(8'h00);
      $display("test empty_frame done");
   endtask : t_empty_frame

   task automatic t_codes();
      logic [7:0] codes [5];
      codes = '{8'h01, 8'h80, 8'hFF, 8'hA5, 8'h5A};
      foreach (codes[i]) begin
         send_bits({8'hC3, codes[i]});
         check_wiper(codes[i]);
      end
      $display("test codes done");
   endtask : t_codes

   task automatic t_deselected_clocks();
      send_bits(16'hFF3C);
      check_wiper(8'h3C);
      dpw_spi_ctrl_model_inst.stray_clocks(9);
      check_wiper(8'h3C);
      dpw_spi_ctrl_model_inst.select();
      dpw_spi_ctrl_model_inst.deselect();
      check_wiper(8'h3C);
      $display("test deselected_clocks done");
   endtask : t_deselected_clocks

   // A second reset must clear the loaded shifter and preset midscale.
   task automatic t_reset_again();
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      check_wiper(8'h80);
      dpw_spi_ctrl_model_inst.stray_clocks(2);
      check_wiper(8'h80);
      dpw_spi_ctrl_model_inst.select();
      dpw_spi_ctrl_model_inst.deselect();
      check_wiper(8'h00);
      $display("test reset_again done");
   endtask : t_reset_again

   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      i_rst      = 1'b1;
      mismatches = 0;
      compares   = 0;
      cycles     = 0;
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_power_up();
      t_empty_frame();
      t_codes();
      t_deselected_clocks();
      t_reset_again();
      finish_test();
   end

endmodule : tb_dpw_wiper_loader
